// *** include/hs_detect_defs.vh ***
`ifndef HS_DETECT_DEFS_VH
`define HS_DETECT_DEFS_VH

// Register offsets on the register port.
`define OFS_DETECT_CTRL_A      7'h0d
`define OFS_DETECT_CTRL_B      7'h0e

// Field positions in the first detection register.
`define A_DETECT_EN_BIT        7
`define A_TYPE_HI              6
`define A_TYPE_LO              5
`define A_JACK_DB_HI           4
`define A_JACK_DB_LO           2
`define A_BTN_DB_HI            1
`define A_BTN_DB_LO            0

// Field positions in the second detection register.
`define B_AC_COUPLED_BIT       7
`define B_FULLY_DIFF_BIT       6
`define B_BTN_FLAG_BIT         5
`define B_PRESENT_BIT          4
`define B_PSEUDO_DIFF_BIT      3

// Reset values.
`define RST_CTRL_A             8'h00
`define RST_CTRL_B             8'h00

// Headset type codes.
`define TYPE_NONE              2'h0
`define TYPE_NO_MIC            2'h1
`define TYPE_WITH_MIC          2'h3

// Button debounce code that disables debouncing.
`define BTN_DB_NONE            2'h0

// Number of equal samples that make up one debounce window.
`define DB_SAMPLES             8

// Base time step and clock period, and the cycles in one base step.
`define BASE_STEP_NS           1000000
`define CLK_PERIOD_NS          25
`define BASE_STEP_CYCLES       (`BASE_STEP_NS / `CLK_PERIOD_NS)

`endif

// *** verilog/sense_debounce.v ***
`include "hs_detect_defs.vh"

// Debounces one sense input on a slow sampling tick.
module sense_debounce
#(
	parameter SAMPLES = `DB_SAMPLES
)
(
	input  wire clk,
	input  wire rst,
	input  wire hold,
	input  wire tick,
	input  wire bypass,
	input  wire din,
	output reg  q_r
);

	reg [3:0] cnt_r;

	// A changed level must be seen on SAMPLES ticks in a row; a return restarts the count.
	always @(posedge clk)
	begin
		if (rst || hold)
		begin
			q_r   <= 1'b0;
			cnt_r <= 4'h0;
		end
		else if (bypass)
		begin
			q_r   <= din;
			cnt_r <= 4'h0;
		end
		else if (tick)
		begin
			if (din == q_r)
				cnt_r <= 4'h0;
			else if (cnt_r == SAMPLES[3:0] - 4'h1)
			begin
				q_r   <= din;
				cnt_r <= 4'h0;
			end
			else
				cnt_r <= cnt_r + 4'h1;
		end
	end

endmodule // sense_debounce

// *** verilog/headset_button_detect_regs.v ***
`include "hs_detect_defs.vh"

// How it works
// - Detection runs only while the enable bit is 1 and is held idle while it is 0.
// - The read-only type field shows 00 for none, 01 without mic, 11 with mic, never 10.
// - A three-bit code picks a jack debounce window of 16, 32, 64, 128, 256, 512 or, for codes 6 and 7, 1024 ms.
// - The jack input is sampled on a tick that is one eighth of the selected window.
// - The coupling bit selects capless outputs at 0 and ac-coupled outputs at 1.
// - Configuration bit A at 1 marks the stereo outputs as fully differential.
// - Configuration bit B at 1 marks the stereo outputs as pseudodifferential.
// - A debounced button press sets a sticky flag that stays set after release.
// - Reading the register that holds the button flag clears it after the read returns.
// - A read-only flag shows 1 while a headset is detected and 0 otherwise.
module headset_button_detect_regs
#(
	parameter STEP_CYCLES = `BASE_STEP_CYCLES
)
(
	input  wire       core_clk,
	input  wire       rst,
	input  wire [6:0] reg_addr,
	input  wire       reg_wr,
	input  wire [7:0] reg_wdata,
	input  wire       reg_rd,
	output reg  [7:0] reg_rdata_r,
	output reg        reg_rvalid_r,
	input  wire       jack_sense,
	input  wire       mic_sense,
	input  wire       button_sense,
	output reg        detect_active_r,
	output reg  [1:0] headset_type_r,
	output reg        headset_present_r,
	output reg        button_flag_r,
	output reg        hp_ac_coupled_r,
	output reg        stereo_fully_diff_r,
	output reg        stereo_pseudo_diff_r
);

	reg  [2:0]  jack_db_r;
	reg  [1:0]  btn_db_r;
	reg  [31:0] step_cnt_r;
	reg         step_tick_r;
	reg  [6:0]  ms_cnt_r;
	reg         btn_q_d_r;
	wire [6:0]  jack_mask;
	wire [6:0]  btn_mask;
	wire        jack_tick;
	wire        btn_tick;
	wire        jack_q;
	wire        mic_q;
	wire        btn_q;
	wire        hold;
	wire        sel_a;
	wire        sel_b;
	wire        btn_press;
	wire [7:0]  rd_a;
	wire [7:0]  rd_b;

	// Reset images of the two registers; the writable fields take their reset bits from these.
	localparam [7:0]  RST_A     = `RST_CTRL_A;
	localparam [7:0]  RST_B     = `RST_CTRL_B;
	// Last count of the base step divider, held at the width of the divider counter.
	localparam [31:0] STEP_LAST = STEP_CYCLES - 1;

	assign sel_a = (reg_addr == `OFS_DETECT_CTRL_A);
	assign sel_b = (reg_addr == `OFS_DETECT_CTRL_B);
	assign hold  = ~detect_active_r;

	// Base step counter makes a one-cycle pulse every millisecond and counts milliseconds.
	always @(posedge core_clk)
	begin
		if (rst || hold)
		begin
			step_cnt_r  <= 32'h0;
			step_tick_r <= 1'b0;
			ms_cnt_r    <= 7'h00;
		end
		else if (step_cnt_r == STEP_LAST)
		begin
			step_cnt_r  <= 32'h0;
			step_tick_r <= 1'b1;
			ms_cnt_r    <= ms_cnt_r + 7'h01;
		end
		else
		begin
			step_cnt_r  <= step_cnt_r + 32'h1;
			step_tick_r <= 1'b0;
		end
	end

	// Jack tick every 2 << code ms, 128 ms for code 7, one eighth of the window; button tick every 1 << (code-1) ms.
	assign jack_mask = (7'h02 << jack_db_r) - 7'h01;
	assign btn_mask  = (7'h01 << (btn_db_r - 2'h1)) - 7'h01;
	assign jack_tick = step_tick_r && ((ms_cnt_r & jack_mask) == jack_mask);
	assign btn_tick  = step_tick_r && ((ms_cnt_r & btn_mask) == btn_mask);

	sense_debounce jack_db_u
	(
		.clk    (core_clk),
		.rst    (rst),
		.hold   (hold),
		.tick   (jack_tick),
		.bypass (1'b0),
		.din    (jack_sense),
		.q_r    (jack_q)
	);

	sense_debounce mic_db_u
	(
		.clk    (core_clk),
		.rst    (rst),
		.hold   (hold),
		.tick   (jack_tick),
		.bypass (1'b0),
		.din    (mic_sense),
		.q_r    (mic_q)
	);

	sense_debounce btn_db_u
	(
		.clk    (core_clk),
		.rst    (rst),
		.hold   (hold),
		.tick   (btn_tick),
		.bypass (btn_db_r == `BTN_DB_NONE),
		.din    (button_sense),
		.q_r    (btn_q)
	);

	// A press counts only on a debounced rising edge while a headset is present.
	assign btn_press = btn_q && !btn_q_d_r && headset_present_r;

	// Read views of the two registers; reserved low bits of the second read as zero.
	assign rd_a = {detect_active_r, headset_type_r, jack_db_r, btn_db_r};
	assign rd_b = {hp_ac_coupled_r, stereo_fully_diff_r, button_flag_r, headset_present_r,
		stereo_pseudo_diff_r, 3'h0};

	// Writable control fields; read-only fields ignore writes.
	always @(posedge core_clk)
	begin
		if (rst)
		begin
			detect_active_r      <= RST_A[`A_DETECT_EN_BIT];
			jack_db_r            <= RST_A[`A_JACK_DB_HI:`A_JACK_DB_LO];
			btn_db_r             <= RST_A[`A_BTN_DB_HI:`A_BTN_DB_LO];
			hp_ac_coupled_r      <= RST_B[`B_AC_COUPLED_BIT];
			stereo_fully_diff_r  <= RST_B[`B_FULLY_DIFF_BIT];
			stereo_pseudo_diff_r <= RST_B[`B_PSEUDO_DIFF_BIT];
		end
		else if (reg_wr && sel_a)
		begin
			detect_active_r <= reg_wdata[`A_DETECT_EN_BIT];
			jack_db_r       <= reg_wdata[`A_JACK_DB_HI:`A_JACK_DB_LO];
			btn_db_r        <= reg_wdata[`A_BTN_DB_HI:`A_BTN_DB_LO];
		end
		else if (reg_wr && sel_b)
		begin
			hp_ac_coupled_r      <= reg_wdata[`B_AC_COUPLED_BIT];
			stereo_fully_diff_r  <= reg_wdata[`B_FULLY_DIFF_BIT];
			stereo_pseudo_diff_r <= reg_wdata[`B_PSEUDO_DIFF_BIT];
		end
	end

	// Detection results follow the debounced senses and clear while detection is off.
	always @(posedge core_clk)
	begin
		if (rst || hold)
		begin
			headset_present_r <= 1'b0;
			headset_type_r    <= `TYPE_NONE;
			btn_q_d_r         <= 1'b0;
		end
		else
		begin
			headset_present_r <= jack_q;
			btn_q_d_r         <= btn_q;
			if (!jack_q)
				headset_type_r <= `TYPE_NONE;
			else if (mic_q)
				headset_type_r <= `TYPE_WITH_MIC;
			else
				headset_type_r <= `TYPE_NO_MIC;
		end
	end

	// Sticky button flag: a new press wins over the clear by a read in the same cycle.
	always @(posedge core_clk)
	begin
		if (rst)
			button_flag_r <= 1'b0;
		else if (btn_press)
			button_flag_r <= 1'b1;
		else if (reg_rd && sel_b)
			button_flag_r <= 1'b0;
	end

	// Read data is registered one cycle after the request; unmapped offsets read zero.
	always @(posedge core_clk)
	begin
		if (rst)
		begin
			reg_rdata_r  <= 8'h00;
			reg_rvalid_r <= 1'b0;
		end
		else
		begin
			reg_rvalid_r <= reg_rd;
			if (reg_rd && sel_a)
				reg_rdata_r <= rd_a;
			else if (reg_rd && sel_b)
				reg_rdata_r <= rd_b;
			else if (reg_rd)
				reg_rdata_r <= 8'h00;
		end
	end

endmodule // headset_button_detect_regs

// *** verification/headset_button_detect_regs_asserts.sv ***
// Watches the register port and the detection results of the block.
module headset_button_detect_regs_asserts(
	input logic       core_clk,
	input logic       rst,
	input logic [6:0] reg_addr,
	input logic       reg_wr,
	input logic [7:0] reg_wdata,
	input logic       reg_rd,
	input logic [7:0] reg_rdata_r,
	input logic       reg_rvalid_r,
	input logic       detect_active_r,
	input logic [1:0] headset_type_r,
	input logic       headset_present_r,
	input logic       button_flag_r,
	input logic       hp_ac_coupled_r,
	input logic       stereo_fully_diff_r,
	input logic       stereo_pseudo_diff_r
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	// Reads of the second register, where the flags live.
	wire rd_b = reg_rd && reg_addr == 7'h0e;
	a_read_answer: assert property (reg_rd |=> reg_rvalid_r)
		else $error("read gave no answer");
	a_read_b_fields: assert property (rd_b |=>
		reg_rdata_r == $past({hp_ac_coupled_r, stereo_fully_diff_r, button_flag_r,
		headset_present_r, stereo_pseudo_diff_r, 3'h0}))
		else $error("second register read wrong");
	a_read_a_fields: assert property (reg_rd && reg_addr == 7'h0d |=>
		reg_rdata_r[7:5] == $past({detect_active_r, headset_type_r}))
		else $error("first register read wrong");
	a_flag_clears: assert property (rd_b && !headset_present_r |=> !button_flag_r)
		else $error("flag kept after read");
	a_flag_sticky: assert property (button_flag_r && !rd_b |=> button_flag_r)
		else $error("flag dropped");
	a_type_legal: assert property (headset_type_r != 2'h2 &&
		headset_present_r == (headset_type_r != 2'h0))
		else $error("type and present disagree");
	a_disable_clears: assert property (!detect_active_r |=> !headset_present_r)
		else $error("present while disabled");
	a_write_b: assert property (reg_wr && reg_addr == 7'h0e |=>
		{hp_ac_coupled_r, stereo_fully_diff_r, stereo_pseudo_diff_r} ==
		$past({reg_wdata[7:6], reg_wdata[3]}))
		else $error("output config not written");
	// Main scenarios reached.
	c_flag: cover property (button_flag_r);
	c_mic: cover property (headset_type_r == 2'h3);
	c_flag_read: cover property (reg_rvalid_r && reg_rdata_r[5]);
endmodule // headset_button_detect_regs_asserts

// *** verification/hs_sense_model.sv ***
// Jack, microphone and button contacts; levels move only on falling edges.
module hs_sense_model(
	input  logic core_clk,
	output logic jack_sense,
	output logic mic_sense,
	output logic button_sense
);
	timeunit 1ns;
	timeprecision 100ps;
	// All contacts open at the start.
	initial
	begin
		jack_sense   = 1'b0;
		mic_sense    = 1'b0;
		button_sense = 1'b0;
	end
	// Sets jack, microphone and button levels at the next falling edge.
	task automatic set(input logic [2:0] v);
		@(negedge core_clk);
		jack_sense   = v[2];
		mic_sense    = v[1];
		button_sense = v[0];
	endtask
endmodule // hs_sense_model

// *** verification/tb_headset_button_detect_regs.sv ***
module tb_headset_button_detect_regs;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int STEP = 10;
	logic       core_clk, rst, reg_wr, reg_rd;
	logic [6:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata_r;
	logic       reg_rvalid_r, jack_sense, mic_sense, button_sense, detect_active_r;
	logic       headset_present_r, button_flag_r, hp_ac_coupled_r;
	logic       stereo_fully_diff_r, stereo_pseudo_diff_r;
	logic [1:0] headset_type_r;
	int         miscompares = 0, checked = 0;
	always #12.5 core_clk = ~core_clk;
	headset_button_detect_regs #(.STEP_CYCLES(STEP)) u_headset_button_detect_regs(
		.core_clk             (core_clk),
		.rst                  (rst),
		.reg_addr             (reg_addr),
		.reg_wr               (reg_wr),
		.reg_wdata            (reg_wdata),
		.reg_rd               (reg_rd),
		.reg_rdata_r          (reg_rdata_r),
		.reg_rvalid_r         (reg_rvalid_r),
		.jack_sense           (jack_sense),
		.mic_sense            (mic_sense),
		.button_sense         (button_sense),
		.detect_active_r      (detect_active_r),
		.headset_type_r       (headset_type_r),
		.headset_present_r    (headset_present_r),
		.button_flag_r        (button_flag_r),
		.hp_ac_coupled_r      (hp_ac_coupled_r),
		.stereo_fully_diff_r  (stereo_fully_diff_r),
		.stereo_pseudo_diff_r (stereo_pseudo_diff_r)
	);
	hs_sense_model u_hs_sense_model(
		.core_clk     (core_clk),
		.jack_sense   (jack_sense),
		.mic_sense    (mic_sense),
		.button_sense (button_sense)
	);
	task automatic chk(input logic [7:0] s, e);
		checked++;
		if (s !== e)
		begin
			miscompares++;
			$display("ERROR %0t: saw %h want %h", $time, s, e);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge core_clk);
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] v);
		@(negedge core_clk);
		reg_addr  = a;
		reg_wdata = v;
		reg_wr    = 1'b1;
		@(negedge core_clk);
		reg_wr = 0;
	endtask
	// Reads one register and compares the answer.
	task automatic rdc(input logic [6:0] a, input logic [7:0] e);
		@(negedge core_clk);
		reg_addr = a;
		reg_rd   = 1'b1;
		@(negedge core_clk);
		reg_rd = 0;
		chk(reg_rvalid_r, 8'h01);
		chk(reg_rdata_r, e);
	endtask
	task automatic wait_present(input int n);
		repeat (n) if (headset_present_r !== 1'b1) @(negedge core_clk);
	endtask
	task automatic t_regs;
		rdc(7'h0d, 8'h00);
		rdc(7'h0e, 8'h00);
		rdc(7'h33, 8'h00);
		wr(7'h0e, 8'h88);
		chk({hp_ac_coupled_r, stereo_fully_diff_r, stereo_pseudo_diff_r}, 8'h05);
		rdc(7'h0e, 8'h88);
		wr(7'h0e, 8'h40);
		chk({hp_ac_coupled_r, stereo_fully_diff_r, stereo_pseudo_diff_r}, 8'h02);
		rdc(7'h0e, 8'h40);
		wr(7'h0e, 8'h00);
		wr(7'h0d, 8'h60);
		rdc(7'h0d, 8'h00);
		$display("done regs");
	endtask
	// Jack windows of codes 0 to 5: not accepted early, accepted in time.
	task automatic t_jack;
		int p;
		for (int c = 0; c < 6; c++)
		begin
			p = (2 << c) * STEP;
			wr(7'h0d, {3'h4, c[2:0], 2'h0});
			u_hs_sense_model.set(3'h6);
			cyc(6 * p);
			chk(headset_present_r, 8'h00);
			wait_present(4 * p);
			rdc(7'h0d, {3'h7, c[2:0], 2'h0});
			chk({detect_active_r, headset_type_r}, 8'h07);
			wr(7'h0d, 8'h00);
			u_hs_sense_model.set(3'h0);
			rdc(7'h0e, 8'h00);
		end
		$display("done jack");
	endtask
	task automatic t_glitch_button;
		wr(7'h0d, 8'h80);
		u_hs_sense_model.set(3'h4);
		cyc(4 * 2 * STEP);
		u_hs_sense_model.set(3'h0);
		cyc(2 * STEP);
		u_hs_sense_model.set(3'h4);
		cyc(6 * 2 * STEP);
		chk(headset_present_r, 8'h00);
		wait_present(8 * STEP);
		wr(7'h0d, 8'h81);
		rdc(7'h0d, 8'ha1);
		chk(headset_type_r, 8'h01);
		u_hs_sense_model.set(3'h5);
		cyc(5 * STEP);
		chk(button_flag_r, 8'h00);
		cyc(6 * STEP);
		u_hs_sense_model.set(3'h4);
		cyc(2 * STEP);
		rdc(7'h0e, 8'h30);
		rdc(7'h0e, 8'h10);
		wr(7'h0d, 8'h80);
		u_hs_sense_model.set(3'h5);
		u_hs_sense_model.set(3'h4);
		cyc(2);
		rdc(7'h0e, 8'h30);
		// A fresh press, then detection is switched off with the jack still in.
		u_hs_sense_model.set(3'h5);
		u_hs_sense_model.set(3'h4);
		cyc(2);
		wr(7'h0d, 8'h00);
		rdc(7'h0e, 8'h20);
		rdc(7'h0e, 8'h00);
		$display("done glitch button");
	endtask
	task automatic finish_test;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial
	begin
		core_clk  = 1'b0;
		rst       = 1'b1;
		reg_wr    = 1'b0;
		reg_rd    = 1'b0;
		reg_addr  = 7'h00;
		reg_wdata = 8'h00;
		cyc(8);
		rst = 0;
		t_regs;
		t_jack;
		t_glitch_button;
		finish_test;
	end
	// Cuts a hang well after the expected run of about 11000 cycles.
	initial
	begin
		#1500000;
		miscompares++;
		finish_test;
	end
endmodule // tb_headset_button_detect_regs
bind headset_button_detect_regs headset_button_detect_regs_asserts u_asserts(
	.core_clk             (core_clk),
	.rst                  (rst),
	.reg_addr             (reg_addr),
	.reg_wr               (reg_wr),
	.reg_wdata            (reg_wdata),
	.reg_rd               (reg_rd),
	.reg_rdata_r          (reg_rdata_r),
	.reg_rvalid_r         (reg_rvalid_r),
	.detect_active_r      (detect_active_r),
	.headset_type_r       (headset_type_r),
	.headset_present_r    (headset_present_r),
	.button_flag_r        (button_flag_r),
	.hp_ac_coupled_r      (hp_ac_coupled_r),
	.stereo_fully_diff_r  (stereo_fully_diff_r),
	.stereo_pseudo_diff_r (stereo_pseudo_diff_r)
);
